// *** hw/dio_consts.vh ***
// Constants of the digital I/O mode, event and register control block.
`ifndef DIO_CONSTS_VH
`define DIO_CONSTS_VH

// Byte addresses on the register bus (low ten address bits).
`define ADDR_INT_REG 10'h000
`define ADDR_PORT_BASE 10'h200
`define ADDR_IRQ_EN 10'h23c
`define PORT_REGION 5'h10

// Port indices inside a bank.
`define PORT_MASK 3'h6
`define PORT_POL_LO 3'h6
`define PORT_SEL 3'h7
`define PORT_DEB_EN 3'h0
`define PORT_DUR_LO 3'h1
`define PORT_DUR_HI 3'h2
`define PORT_CLK_SEL 3'h3

// Bank codes held in bits 7 and 6 of the bank register.
`define BANK_IO 2'h0
`define BANK_EVENT 2'h1
`define BANK_DEB 2'h2

// Unlock sequence written to port 7.
`define UNLOCK_B0 8'h07
`define UNLOCK_B1 8'h0d
`define UNLOCK_B2 8'h06
`define UNLOCK_B3 8'h12

// Bit positions in the interrupt enable and soft reset register.
`define IRQ_EN_BIT 0
`define SOFT_RST_BIT 1
`define IRQ_EN_UNUSED 6'h3f

// Reset values.
`define RST_OUT 1'b0
`define RST_MASK 1'b0
`define RST_POL 1'b0
`define RST_BANK 2'h0
`define RST_LEVEL 1'b1

// Clock rate and debounce tick periods; a line must hold for four ticks.
`define CLK_MHZ 10
`define DEB_T0_NS 1000
`define DEB_T1_NS 16000
`define DEB_T2_NS 250000
`define DEB_T3_NS 2000000
`define DEB_CYC0 (`DEB_T0_NS * `CLK_MHZ / 1000)
`define DEB_CYC1 (`DEB_T1_NS * `CLK_MHZ / 1000)
`define DEB_CYC2 (`DEB_T2_NS * `CLK_MHZ / 1000)
`define DEB_CYC3 (`DEB_T3_NS * `CLK_MHZ / 1000)

`endif

// *** hw/dio_event_ctrl.v ***
// Digital I/O ports, enhanced mode unlock, bank select, event sensing and interrupt request.
// Behaviour
// RULE_01: Bank bits 7:6 pick register group.
// RULE_02: Software never writes bank code 11.
// RULE_03: Enable bit 0 gates interrupt line drive.
// RULE_04: Enable resets on system reset only.
// RULE_05: Interrupt register bit 0 also required.
// RULE_06: Bit 1 write triggers soft reset, reads 0.
// RULE_07: Soft reset clears field logic only.
// RULE_08: Software keeps bit 0 during soft reset.
// RULE_09: Reset releases outputs, returns standard mode.
// RULE_10: Reset clears the port write mask.
// RULE_11: Reset clears, disables events, falling polarity.
// RULE_12: Six eight-line ports, eight ports per bank.
// RULE_13: Port reads return inverted pin level.
// RULE_14: Written bits latch, drive lines open-drain inverted.
// RULE_15: Masked ports block writes; outputs read back.
// RULE_16: Four-byte port 7 unlock enters enhanced mode; code ignores it while enable bit 0 is set.
// RULE_17: Software unlocks right after reset.
// RULE_18: Event sensing per line, enhanced mode only.
// RULE_19: Polarity per nibble, enable per channel.
// RULE_20: Software sets polarity before enabling events.
// RULE_21: Optional debounce filter in enhanced mode.
// RULE_22: Polarity 0 falling, 1 rising.
// RULE_23: Writing 0 clears flag; 1 re-arms.
// RULE_24: Request holds until flag cleared.
// RULE_25: Bank register reads code, low bits zero.
//
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/10ps
`include "dio_consts.vh"

module dio_event_ctrl #(
	parameter NUM_PORTS = 6,
	parameter DEB_CYC0 = `DEB_CYC0,
	parameter DEB_CYC1 = `DEB_CYC1,
	parameter DEB_CYC2 = `DEB_CYC2,
	parameter DEB_CYC3 = `DEB_CYC3
) (
	// Clock and reset.
	input wire ref_clk,
	input wire rst_n,
	// AHB-Lite slave.
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire hreadyout,
	output reg [31:0] hrdata,
	output wire hresp,
	// Field I/O lines, open-drain.
	input wire [NUM_PORTS*8-1:0] io_in,
	output wire [NUM_PORTS*8-1:0] io_out,
	output wire [NUM_PORTS*8-1:0] io_oe,
	// Interrupt request line, open-drain, active low.
	output wire irq_out_n,
	output reg irq_oe
);

localparam NL = NUM_PORTS * 8;
localparam [1:0] UNL_IDLE = 2'h0;
localparam [1:0] UNL_GOT1 = 2'h1;
localparam [1:0] UNL_GOT2 = 2'h2;
localparam [1:0] UNL_GOT3 = 2'h3;

////////////////////////////////////////////////////////////////////////////////
// Reset synchroniser.
reg rst_s1;
reg sys_rst_n;
always @(posedge ref_clk or negedge rst_n) begin
	if (!rst_n) begin
		rst_s1 <= 1'b0;
		sys_rst_n <= 1'b0;
	end else begin
		rst_s1 <= 1'b1;
		sys_rst_n <= rst_s1;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Bus address and data phase.
reg dp_valid;
reg dp_write;
reg [9:0] dp_addr;
wire ap_valid = hsel & htrans[1] & hready;
wire [9:0] ap_addr = haddr[9:0];
wire ap_port_hit = (ap_addr[9:5] == `PORT_REGION);
wire [2:0] ap_port = ap_addr[4:2];
wire dp_port_hit = (dp_addr[9:5] == `PORT_REGION);
wire [2:0] dp_port = dp_addr[4:2];
wire [7:0] wd = hwdata[7:0];
wire dp_wr = dp_valid & dp_write;

assign hreadyout = 1'b1;
assign hresp = 1'b0;

always @(posedge ref_clk or negedge sys_rst_n) begin
	if (!sys_rst_n) begin
		dp_valid <= 1'b0;
		dp_write <= 1'b0;
		dp_addr <= 10'h000;
	end else begin
		dp_valid <= ap_valid;
		dp_write <= hwrite;
		dp_addr <= ap_addr;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Registers outside the field logic.
reg irq_en;
reg int_reg;
reg soft_rst;
always @(posedge ref_clk or negedge sys_rst_n) begin
	if (!sys_rst_n) begin
		irq_en <= 1'b0;
		int_reg <= 1'b0;
		soft_rst <= 1'b0;
	end else begin
		// RULE_06 soft reset pulse
		soft_rst <= dp_wr & (dp_addr == `ADDR_IRQ_EN) & wd[`SOFT_RST_BIT];
		// RULE_04 kept over soft reset
		if (dp_wr && dp_addr == `ADDR_IRQ_EN)
			irq_en <= wd[`IRQ_EN_BIT];
		if (dp_wr && dp_addr == `ADDR_INT_REG)
			int_reg <= wd[0];
	end
end

////////////////////////////////////////////////////////////////////////////////
// Mode, unlock and configuration registers of the field logic.
reg enh;
reg [1:0] unl_state;
reg [1:0] bank;
reg [NUM_PORTS-1:0] mask;
reg [NUM_PORTS*2-1:0] pol;
reg [NUM_PORTS-1:0] deb_en;
reg [NUM_PORTS*2-1:0] dur;
reg clk_sel;
wire [NL-1:0] out_latch;
reg [1:0] next_unl;
reg [7:0] unl_expect;

always @* begin
	case (unl_state)
		UNL_IDLE: unl_expect = `UNLOCK_B0;
		UNL_GOT1: unl_expect = `UNLOCK_B1;
		UNL_GOT2: unl_expect = `UNLOCK_B2;
		UNL_GOT3: unl_expect = `UNLOCK_B3;
		default: unl_expect = `UNLOCK_B0;
	endcase
end

wire std_sel_wr = dp_wr & dp_port_hit & (dp_port == `PORT_SEL) & ~enh;
// RULE_16 other port access breaks the sequence
wire unl_break = ap_valid & ap_port_hit & ~(hwrite & ap_port == `PORT_SEL);

always @* begin
	next_unl = unl_state;
	if (unl_break) begin
		next_unl = UNL_IDLE;
	end else if (std_sel_wr) begin
		if (wd == unl_expect && !irq_en)
			next_unl = unl_state + 2'h1;
		else if (wd == `UNLOCK_B0 && !irq_en)
			next_unl = UNL_GOT1;
		else
			next_unl = UNL_IDLE;
	end
end

wire bank_wr = dp_wr & dp_port_hit & enh & (dp_port == `PORT_SEL);
wire io_bank = ~enh | (bank == `BANK_IO);
wire ev_bank = enh & (bank == `BANK_EVENT);
wire deb_bank = enh & (bank == `BANK_DEB);

always @(posedge ref_clk or negedge sys_rst_n) begin
	if (!sys_rst_n) begin
		enh <= 1'b0;
		unl_state <= UNL_IDLE;
		bank <= `RST_BANK;
		mask <= {NUM_PORTS{`RST_MASK}};
		pol <= {(NUM_PORTS*2){`RST_POL}};
		deb_en <= {NUM_PORTS{1'b0}};
		dur <= {(NUM_PORTS*2){1'b0}};
		clk_sel <= 1'b0;
	end else if (soft_rst) begin
		// RULE_07 field logic only
		// RULE_09 back to standard mode
		enh <= 1'b0;
		unl_state <= UNL_IDLE;
		bank <= `RST_BANK;
		// RULE_10 mask cleared
		mask <= {NUM_PORTS{`RST_MASK}};
		// RULE_11 falling polarity restored
		pol <= {(NUM_PORTS*2){`RST_POL}};
		deb_en <= {NUM_PORTS{1'b0}};
		dur <= {(NUM_PORTS*2){1'b0}};
		clk_sel <= 1'b0;
	end else begin
		// RULE_16 unlock sequence tracker
		unl_state <= next_unl;
		if (std_sel_wr && !unl_break && unl_state == UNL_GOT3 && wd == `UNLOCK_B3 && !irq_en)
			enh <= 1'b1;
		// RULE_01 bank code store
		if (bank_wr)
			bank <= wd[7:6];
		// RULE_15 write mask register
		if (dp_wr && dp_port_hit && io_bank && dp_port == `PORT_MASK)
			mask <= wd[NUM_PORTS-1:0];
		// RULE_19 nibble polarity writes
		if (dp_wr && dp_port_hit && ev_bank && dp_port == `PORT_POL_LO)
			pol[7:0] <= wd;
		if (bank_wr && bank == `BANK_EVENT)
			pol[NUM_PORTS*2-1:8] <= wd[NUM_PORTS*2-9:0];
		if (dp_wr && dp_port_hit && deb_bank) begin
			if (dp_port == `PORT_DEB_EN)
				deb_en <= wd[NUM_PORTS-1:0];
			if (dp_port == `PORT_DUR_LO)
				dur[7:0] <= wd;
			if (dp_port == `PORT_DUR_HI)
				dur[NUM_PORTS*2-1:8] <= wd[NUM_PORTS*2-9:0];
			if (dp_port == `PORT_CLK_SEL)
				clk_sel <= wd[0];
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Debounce tick generators, one per duration code.
wire [3:0] tick;
genvar k;
generate
	for (k = 0; k < 4; k = k + 1) begin : g_tick
		localparam integer LIM = (k == 0) ? DEB_CYC0 : (k == 1) ? DEB_CYC1 :
			(k == 2) ? DEB_CYC2 : DEB_CYC3;
		reg [23:0] cnt;
		assign tick[k] = (cnt == LIM[23:0] - 24'h000001);
		always @(posedge ref_clk or negedge sys_rst_n) begin
			if (!sys_rst_n)
				cnt <= 24'h000000;
			else if (tick[k])
				cnt <= 24'h000000;
			else
				cnt <= cnt + 24'h000001;
		end
	end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// Per line: synchroniser, debounce, output latch and event flag.
reg [NL-1:0] io_s1;
reg [NL-1:0] io_s2;
always @(posedge ref_clk or negedge sys_rst_n) begin
	if (!sys_rst_n) begin
		io_s1 <= {NL{`RST_LEVEL}};
		io_s2 <= {NL{`RST_LEVEL}};
	end else begin
		io_s1 <= io_in;
		io_s2 <= io_s1;
	end
end

wire [NL-1:0] level;
wire [NL-1:0] flag;
wire io_wr = dp_wr & dp_port_hit & io_bank;
wire ev_wr = dp_wr & dp_port_hit & ev_bank;

genvar i;
generate
	for (i = 0; i < NL; i = i + 1) begin : g_line
		localparam integer P = i / 8;
		localparam integer B = i % 8;
		localparam integer N = i / 4;
		reg filt;
		reg prev;
		reg [1:0] cnt;
		reg en;
		reg flg;
		reg olat;
		wire [1:0] code = dur[2*P+1:2*P];
		// RULE_22 polarity selects edge
		wire hit = pol[N] ? (~prev & filt) : (prev & ~filt);
		assign level[i] = filt;
		assign flag[i] = flg;
		assign out_latch[i] = olat;
		always @(posedge ref_clk or negedge sys_rst_n) begin
			if (!sys_rst_n) begin
				filt <= `RST_LEVEL;
				prev <= `RST_LEVEL;
				cnt <= 2'h0;
				olat <= `RST_OUT;
				en <= 1'b0;
				flg <= 1'b0;
			end else if (soft_rst) begin
				// RULE_09 outputs released high
				olat <= `RST_OUT;
				// RULE_11 events cleared and disabled
				en <= 1'b0;
				flg <= 1'b0;
				cnt <= 2'h0;
				filt <= io_s2[i];
				prev <= io_s2[i];
			end else begin
				prev <= filt;
				// RULE_21 debounce filter
				if (!(enh && deb_en[P])) begin
					filt <= io_s2[i];
					cnt <= 2'h0;
				end else if (io_s2[i] == filt) begin
					cnt <= 2'h0;
				end else if (tick[code]) begin
					if (cnt == 2'h3) begin
						filt <= io_s2[i];
						cnt <= 2'h0;
					end else begin
						cnt <= cnt + 2'h1;
					end
				end
				// RULE_14 output latch write
				// RULE_15 masked port ignores writes
				if (io_wr && dp_port == P[2:0] && !mask[P])
					olat <= wd[B];
				// RULE_23 clear and re-arm
				if (ev_wr && dp_port == P[2:0]) begin
					en <= wd[B];
					flg <= wd[B] & (flg | (en & hit));
				// RULE_18 sense in enhanced mode only
				end else if (enh && en && hit) begin
					flg <= 1'b1;
				end
			end
		end
	end
endgenerate

// RULE_14 open-drain drive of inverted latch
assign io_out = {NL{1'b0}};
assign io_oe = out_latch;
assign irq_out_n = 1'b0;

////////////////////////////////////////////////////////////////////////////////
// Interrupt request and read data.
always @(posedge ref_clk or negedge sys_rst_n) begin
	if (!sys_rst_n)
		irq_oe <= 1'b0;
	else
		// RULE_03 RULE_05 RULE_24 request while any flag stands
		irq_oe <= irq_en & int_reg & (|flag);
end

reg [7:0] rd_val;
always @* begin
	rd_val = 8'h00;
	if (ap_addr == `ADDR_INT_REG) begin
		rd_val = {7'h00, int_reg};
	end else if (ap_addr == `ADDR_IRQ_EN) begin
		// RULE_06 trigger bit reads zero
		rd_val = {`IRQ_EN_UNUSED, 1'b0, irq_en};
	end else if (ap_port_hit) begin
		if (enh && ap_port == `PORT_SEL) begin
			// RULE_25 bank code readback
			rd_val = {bank, 6'h00};
		end else if (io_bank) begin
			// RULE_12 six byte ports
			// RULE_13 inverted pin level
			if (ap_port < NUM_PORTS)
				rd_val = ~level[ap_port*8 +: 8];
			else if (ap_port == `PORT_MASK)
				rd_val = {{(8-NUM_PORTS){1'b0}}, mask};
		end else if (ev_bank) begin
			if (ap_port < NUM_PORTS)
				rd_val = flag[ap_port*8 +: 8];
			else if (ap_port == `PORT_POL_LO)
				rd_val = pol[7:0];
		end else if (deb_bank) begin
			case (ap_port)
				`PORT_DEB_EN: rd_val = {{(8-NUM_PORTS){1'b0}}, deb_en};
				`PORT_DUR_LO: rd_val = dur[7:0];
				`PORT_DUR_HI: rd_val = {{(16-NUM_PORTS*2){1'b0}}, dur[NUM_PORTS*2-1:8]};
				`PORT_CLK_SEL: rd_val = {7'h00, clk_sel};
				default: rd_val = 8'h00;
			endcase
		end
	end
end

always @(posedge ref_clk or negedge sys_rst_n) begin
	if (!sys_rst_n)
		hrdata <= 32'h00000000;
	else if (ap_valid && !hwrite)
		hrdata <= {24'h000000, rd_val};
end

endmodule

// *** bench/dio_event_ctrl_monitor.sv ***
// Port checker for the digital I/O block.
`timescale 1ns/10ps
module dio_event_ctrl_monitor #(
	parameter NUM_PORTS = 6
) (
	// Clock, reset and bus.
	input wire ref_clk,
	input wire rst_n,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire hready,
	input wire [31:0] hrdata,
	// Field and request lines.
	input wire [NUM_PORTS*8-1:0] io_out,
	input wire [NUM_PORTS*8-1:0] io_oe,
	input wire irq_out_n,
	input wire irq_oe
);
	wire ap = hsel && htrans[1] && hready;
	wire wr = ap && hwrite;
	wire rd_ier = ap && !hwrite && haddr[9:0] == 10'h23c;
	wire rd_bank = ap && !hwrite && haddr[9:0] == 10'h21c;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	property p_sr_zero; rd_ier |=> hrdata[1] == 1'b0; endproperty
	a_sr_zero: assert property (p_sr_zero)
		else $error("Reset trigger bit read high.");
	property p_bank_low; rd_bank |=> hrdata[5:0] == 6'h00; endproperty
	a_bank_low: assert property (p_bank_low)
		else $error("Bank read low bits not zero.");
	property p_od_low; io_out == 0; endproperty
	a_od_low: assert property (p_od_low)
		else $error("Line driven high.");
	property p_irq_val; irq_out_n == 1'b0; endproperty
	a_irq_val: assert property (p_irq_val)
		else $error("Request level wrong.");
	property p_rst_off; $rose(rst_n) |-> (io_oe == 0) [*4]; endproperty
	a_rst_off: assert property (p_rst_off)
		else $error("Output on after reset.");
	property p_rst_quiet; $rose(rst_n) |-> !irq_oe [*8]; endproperty
	a_rst_quiet: assert property (p_rst_quiet)
		else $error("Request after reset.");
	property p_oe_cause;
		!$stable(io_oe) |-> $past(wr) || $past(wr, 2) || $past(wr, 3) || $past(wr, 4);
	endproperty
	a_oe_cause: assert property (p_oe_cause)
		else $error("Output changed without write.");
	property p_irq_drop;
		$fell(irq_oe) |-> $past(wr) || $past(wr, 2) || $past(wr, 3) || $past(wr, 4);
	endproperty
	a_irq_drop: assert property (p_irq_drop)
		else $error("Request dropped without write.");
endmodule
bind dio_event_ctrl dio_event_ctrl_monitor #(.NUM_PORTS(NUM_PORTS)) dio_event_ctrl_monitor_inst (
	.ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hready(hready), .hrdata(hrdata), .io_out(io_out), .io_oe(io_oe),
	.irq_out_n(irq_out_n), .irq_oe(irq_oe));

// *** bench/field_side.sv ***
// Field equipment model on the open-drain lines.
`timescale 1ns/10ps
module field_side (
	// Line drive.
	input wire [47:0] io_oe,
	input wire [47:0] ext_low,
	// Line level.
	output wire [47:0] io_in
);
	assign io_in = ~(io_oe | ext_low);
endmodule

// *** bench/tb_dio_event_ctrl.sv ***
// Self-checking testbench for the digital I/O event block.
`timescale 1ns/10ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin num_errors++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb_dio_event_ctrl;
	logic ref_clk = 0, rst_n = 0, hsel = 0, hwrite = 0;
	logic [31:0] haddr = 0, hwdata = 0;
	logic [1:0] htrans = 0;
	logic [2:0] hsize = 3'h2;
	logic [47:0] ext_low = 0;
	logic [7:0] r;
	wire hready, hresp, irq_out_n, irq_oe;
	wire [31:0] hrdata;
	wire [47:0] io_in, io_out, io_oe;
	int num_errors = 0, checked = 0;
	dio_event_ctrl #(.DEB_CYC0(2), .DEB_CYC1(3), .DEB_CYC2(4), .DEB_CYC3(5)) dio_event_ctrl_inst (
		.ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hready), .hrdata(hrdata), .hresp(hresp), .io_in(io_in),
		.io_out(io_out), .io_oe(io_oe), .irq_out_n(irq_out_n), .irq_oe(irq_oe));
	field_side field_side_inst (.io_oe(io_oe), .ext_low(ext_low), .io_in(io_in));
	initial forever #50 ref_clk = ~ref_clk;
	////////////////////////////////////////////////////////////////////////
	task wt(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task xfer(input [9:0] a, input w, input [7:0] d);
		haddr <= {22'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		hsel <= 1'b1;
		@(posedge ref_clk);
		while (!hready) @(posedge ref_clk);
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		@(posedge ref_clk);
		while (!hready) @(posedge ref_clk);
		r = hrdata[7:0];
	endtask
	task t_reset;
		`CHK(io_oe, 48'h0)
		xfer(10'h200, 0, 0);
		`CHK(r, 8'h00)
		xfer(10'h23c, 0, 0);
		`CHK(r, 8'hfc)
	endtask
	task t_io;
		ext_low[7:0] <= 8'h3c;
		xfer(10'h204, 1, 8'ha5);
		wt(4);
		`CHK(io_oe[15:8], 8'ha5)
		xfer(10'h204, 0, 0);
		`CHK(r, 8'ha5)
		xfer(10'h200, 0, 0);
		`CHK(r, 8'h3c)
		xfer(10'h218, 1, 8'h02);
		xfer(10'h204, 1, 8'hff);
		wt(2);
		`CHK(io_oe[15:8], 8'ha5)
		xfer(10'h300, 0, 0);
		`CHK(r, 8'h00)
	endtask
	task t_event;
		xfer(10'h21c, 1, 8'h07);
		xfer(10'h21c, 1, 8'h0d);
		xfer(10'h200, 0, 0);
		xfer(10'h21c, 1, 8'h06);
		xfer(10'h21c, 1, 8'h12);
		xfer(10'h21c, 1, 8'h80);
		xfer(10'h21c, 0, 0);
		`CHK(r, 8'h00)
		xfer(10'h23c, 1, 8'h02);
		wt(3);
		xfer(10'h21c, 1, 8'h07);
		xfer(10'h21c, 1, 8'h0d);
		xfer(10'h21c, 1, 8'h06);
		xfer(10'h21c, 1, 8'h12);
		xfer(10'h21c, 0, 0);
		`CHK(r, 8'h00)
		xfer(10'h21c, 1, 8'h80);
		xfer(10'h21c, 0, 0);
		`CHK(r, 8'h80)
		xfer(10'h21c, 1, 8'h40);
		xfer(10'h218, 1, 8'h01);
		xfer(10'h200, 1, 8'hff);
		ext_low[7:0] <= 8'h78;
		wt(8);
		xfer(10'h200, 0, 0);
		`CHK(r, 8'h44)
		xfer(10'h000, 1, 8'h01);
		wt(2);
		`CHK(irq_oe, 1'b0)
		xfer(10'h23c, 1, 8'h01);
		wt(2);
		`CHK(irq_oe, 1'b1)
		xfer(10'h000, 1, 8'h00);
		wt(2);
		`CHK(irq_oe, 1'b0)
		xfer(10'h000, 1, 8'h01);
		wt(2);
		`CHK(irq_oe, 1'b1)
		xfer(10'h200, 1, 8'hbb);
		wt(2);
		`CHK(irq_oe, 1'b0)
	endtask
	task t_soft;
		xfer(10'h21c, 1, 8'h00);
		xfer(10'h204, 1, 8'ha5);
		xfer(10'h218, 1, 8'h02);
		xfer(10'h21c, 1, 8'h40);
		wt(2);
		`CHK(io_oe[15:8], 8'ha5)
		xfer(10'h23c, 1, 8'h03);
		wt(3);
		`CHK(io_oe, 48'h0)
		xfer(10'h23c, 0, 0);
		`CHK(r, 8'hfd)
		xfer(10'h21c, 0, 0);
		`CHK(r, 8'h00)
		xfer(10'h204, 1, 8'hff);
		wt(2);
		`CHK(io_oe[15:8], 8'hff)
	endtask
	////////////////////////////////////////////////////////////////////////
	task wrap_up;
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	initial begin
		repeat (3000) @(posedge ref_clk);
		num_errors++;
		wrap_up;
	end
	initial begin
		repeat (12) @(posedge ref_clk);
		rst_n <= 1'b1;
		wt(3);
		t_reset;
		t_io;
		t_event;
		t_soft;
		wrap_up;
	end
endmodule
